// File: inc/spi_slave_pkg.sv
// =============================================================================
// Shared constants of the serial register access port
// =============================================================================
package spi_slave_pkg;

    // Widths
    localparam int BYTE_W     = 8;
    localparam int ADDR_W     = 7;
    localparam int PAIR_W     = ADDR_W + BYTE_W;
    localparam int CNT_W      = 3;

    // Field positions inside the control byte and the write pair
    localparam int RW_POS     = 7;
    localparam int PAIR_ADDR_LSB = BYTE_W;

    // Write FIFO shape
    localparam int FIFO_DEPTH = 8;

    // Pin synchroniser lanes
    localparam int PIN_N      = 3;
    localparam int PIN_CSB    = 0;
    localparam int PIN_SCK    = 1;
    localparam int PIN_SDI    = 2;

    // Reset values and the last bit count
    localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;
    localparam logic [CNT_W-1:0]  LAST_BIT = 3'h7;

    // Frame states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CMD,
        ST_WDATA,
        ST_READ
    } frame_state_t;

endpackage : spi_slave_pkg

// File: inc/stream_if.sv
`timescale 1ns/1ps
// =============================================================================
// Valid/ready word stream between internal modules
// =============================================================================
interface stream_if #(
    parameter int WIDTH = 8
);
    logic [WIDTH-1:0] data;
    logic             valid;
    logic             ready;

    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : stream_if

// File: src/pair_fifo.sv
`timescale 1ns/1ps
// =============================================================================
// Synchronous FIFO, honest full and empty
// =============================================================================
module pair_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic reset_n,
    // Filling and draining sides
    stream_if.snk     fill,
    stream_if.src     drain
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q, wr_ptr_d;
    logic [PTR_W-1:0] rd_ptr_q, rd_ptr_d;
    logic [PTR_W:0]   count_q,  count_d;
    logic             push;
    logic             pop;

    // Full and empty come straight from the occupancy count
    assign fill.ready  = (count_q != (PTR_W+1)'(DEPTH));
    assign drain.valid = (count_q != '0);
    assign drain.data  = mem[rd_ptr_q];
    assign push        = fill.valid & fill.ready;
    assign pop         = drain.valid & drain.ready;

    // Pointer and count update
    always_comb
    begin
        wr_ptr_d = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
        rd_ptr_d = pop  ? rd_ptr_q + 1'b1 : rd_ptr_q;
        count_d  = count_q;
        if (push && !pop)
        begin
            count_d = count_q + 1'b1;
        end
        else if (pop && !push)
        begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end
        else
        begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q  <= count_d;
        end
    end

    // Storage has no reset; only entries counted as valid are read
    always_ff @(posedge sys_clk)
    begin
        if (push)
        begin
            mem[wr_ptr_q] <= fill.data;
        end
    end

endmodule : pair_fifo

// File: src/spi_register_access_slave.sv
`timescale 1ns/1ps
// Operation
// - Mode 00 or 11 picked from clock level seen just after select falls
// - Three-wire mode when three_wire_enable is 1; same framing either way
// - Three-wire: data in pin is bidirectional, data out pin stays undriven
// - Each select-low period is one transaction, opened and closed by host
// - Input bits captured on serial clock rising edges
// - Output bit changes on serial clock falling edges
// - Control byte: bit 7 read flag, low 7 bits register address
// - Writes are control/data pairs, repeatable in one frame, no increment
// - After a read control byte, data shifts out on the active data pin
// - Read address increments after each byte sent
// - First select-low disables the I2C port until power-on reset
module spi_register_access_slave
    import spi_slave_pkg::*;
(
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              reset_n,
    // Serial pins
    input  wire logic              chip_select_low,
    input  wire logic              serial_clk,
    input  wire logic              serial_in_pin_i,
    output logic                   serial_in_pin_o,
    output logic                   serial_in_pin_oe,
    output logic                   serial_out_pin_o,
    output logic                   serial_out_pin_oe,
    // Configuration and status
    input  wire logic              three_wire_enable,
    output logic                   i2c_disable,
    output logic                   write_overflow,
    // Register file write side
    output logic                   reg_wr_valid,
    input  wire logic              reg_wr_ready,
    output logic [ADDR_W-1:0]      reg_wr_addr,
    output logic [BYTE_W-1:0]      reg_wr_data,
    // Register file read side
    output logic [ADDR_W-1:0]      reg_rd_addr,
    input  wire logic [BYTE_W-1:0] reg_rd_data
);

    // =========================================================================
    // Pin synchronisers
    // =========================================================================
    logic [PIN_N-1:0] meta_q;
    logic [PIN_N-1:0] pin_q;
    logic [PIN_N-1:0] pin_prev_q;

    // Two flops per pin; the third stage only serves edge detection
    for (genvar i = 0; i < PIN_N; i++)
    begin : g_sync
        always_ff @(posedge sys_clk or negedge reset_n)
        begin
            if (!reset_n)
            begin
                meta_q[i]     <= 1'b1;
                pin_q[i]      <= 1'b1;
                pin_prev_q[i] <= 1'b1;
            end
            else
            begin
                meta_q[i]     <= (i == PIN_CSB) ? chip_select_low :
                                 (i == PIN_SCK) ? serial_clk : serial_in_pin_i;
                pin_q[i]      <= meta_q[i];
                pin_prev_q[i] <= pin_q[i];
            end
        end
    end

    logic cs_low;
    logic cs_fall;
    logic sck_rise;
    logic sck_fall;
    logic sdi_bit;

    // Clock and data share the same delay, so data lines up with each edge
    assign cs_low   = ~pin_q[PIN_CSB];
    assign cs_fall  = cs_low & pin_prev_q[PIN_CSB];
    assign sck_rise = pin_q[PIN_SCK] & ~pin_prev_q[PIN_SCK];
    assign sck_fall = ~pin_q[PIN_SCK] & pin_prev_q[PIN_SCK];
    assign sdi_bit  = pin_q[PIN_SDI];

    // =========================================================================
    // Write pair FIFO and output stage
    // =========================================================================
    stream_if #(.WIDTH(PAIR_W)) fill_s ();
    stream_if #(.WIDTH(PAIR_W)) drain_s ();

    pair_fifo #(
        .WIDTH (PAIR_W),
        .DEPTH (FIFO_DEPTH)
    ) pair_fifo_inst (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .fill    (fill_s.snk),
        .drain   (drain_s.src)
    );

    logic              out_valid_q, out_valid_d;
    logic [PAIR_W-1:0] out_data_q,  out_data_d;

    // Output register keeps the write port glitch free; drains on ready
    assign drain_s.ready = ~out_valid_q | reg_wr_ready;

    always_comb
    begin
        out_valid_d = out_valid_q;
        out_data_d  = out_data_q;
        if (drain_s.valid && drain_s.ready)
        begin
            out_valid_d = 1'b1;
            out_data_d  = drain_s.data;
        end
        else if (reg_wr_ready)
        begin
            out_valid_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            out_valid_q <= 1'b0;
            out_data_q  <= '0;
        end
        else
        begin
            out_valid_q <= out_valid_d;
            out_data_q  <= out_data_d;
        end
    end

    assign reg_wr_valid = out_valid_q;
    assign reg_wr_addr  = out_data_q[PAIR_W-1:PAIR_ADDR_LSB];
    assign reg_wr_data  = out_data_q[BYTE_W-1:0];

    // =========================================================================
    // Frame engine
    // =========================================================================
    frame_state_t      state_q,   state_d;
    logic [CNT_W-1:0]  cnt_q,     cnt_d;
    logic [BYTE_W-1:0] rx_q,      rx_d;
    logic [BYTE_W-1:0] tx_q,      tx_d;
    logic [BYTE_W-1:0] rd_byte_q, rd_byte_d;
    logic [ADDR_W-1:0] addr_q,    addr_d;
    logic [ADDR_W-1:0] rd_addr_q, rd_addr_d;
    logic              fetch_q,   fetch_d;
    logic              mode11_q,  mode11_d;
    logic              three_q,   three_d;
    logic              drive_q,   drive_d;
    logic              bit_q,     bit_d;
    logic              i2c_off_q, i2c_off_d;
    logic              ovf_q,     ovf_d;
    logic              si_oe_q,   so_oe_q;
    logic [BYTE_W-1:0] byte_in;
    logic              push;

    assign byte_in = {rx_q[BYTE_W-2:0], sdi_bit};

    // One pass per clock: frame control, bit shifting, read fetch
    always_comb
    begin
        state_d   = state_q;
        cnt_d     = cnt_q;
        rx_d      = rx_q;
        tx_d      = tx_q;
        rd_byte_d = fetch_q ? reg_rd_data : rd_byte_q;
        addr_d    = addr_q;
        rd_addr_d = rd_addr_q;
        fetch_d   = 1'b0;
        mode11_d  = mode11_q;
        three_d   = three_q;
        drive_d   = drive_q;
        bit_d     = bit_q;
        i2c_off_d = i2c_off_q | cs_low;
        ovf_d     = ovf_q;
        push      = 1'b0;
        if (cs_fall)
        begin
            // Host holds the clock still here, so its level names the mode
            state_d  = ST_CMD;
            cnt_d    = '0;
            mode11_d = pin_q[PIN_SCK];
            three_d  = three_wire_enable;
            ovf_d    = 1'b0;
        end
        else if (!cs_low)
        begin
            // Frame over: stop driving and forget any partial byte
            state_d = ST_IDLE;
            cnt_d   = '0;
            drive_d = 1'b0;
        end
        else if (state_q != ST_IDLE)
        begin
            if (sck_rise)
            begin
                rx_d  = byte_in;
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == LAST_BIT)
                begin
                    case (state_q)
                        ST_CMD:
                        begin
                            addr_d = byte_in[ADDR_W-1:0];
                            if (byte_in[RW_POS])
                            begin
                                state_d   = ST_READ;
                                rd_addr_d = byte_in[ADDR_W-1:0];
                                fetch_d   = 1'b1;
                            end
                            else
                            begin
                                state_d = ST_WDATA;
                            end
                        end
                        ST_WDATA:
                        begin
                            // Pair done; next byte is a fresh control byte
                            push    = fill_s.ready;
                            ovf_d   = ovf_q | ~fill_s.ready;
                            state_d = ST_CMD;
                        end
                        ST_READ:
                        begin
                            rd_addr_d = addr_q + 1'b1;
                            addr_d    = addr_q + 1'b1;
                            fetch_d   = 1'b1;
                        end
                        default:
                        begin
                            state_d = ST_IDLE;
                        end
                    endcase
                end
            end
            else if (sck_fall && state_q == ST_READ)
            begin
                // Mode 11 also falls once before the first bit, still in ST_CMD
                drive_d = 1'b1;
                if (cnt_q == '0)
                begin
                    bit_d = rd_byte_q[BYTE_W-1];
                    tx_d  = {rd_byte_q[BYTE_W-2:0], 1'b0};
                end
                else
                begin
                    bit_d = tx_q[BYTE_W-1];
                    tx_d  = {tx_q[BYTE_W-2:0], 1'b0};
                end
            end
        end
    end

    assign fill_s.valid = push;
    assign fill_s.data  = {addr_q, byte_in};

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q   <= ST_IDLE;
            cnt_q     <= '0;
            rx_q      <= BYTE_RST;
            tx_q      <= BYTE_RST;
            rd_byte_q <= BYTE_RST;
            addr_q    <= ADDR_RST;
            rd_addr_q <= ADDR_RST;
            fetch_q   <= 1'b0;
            mode11_q  <= 1'b0;
            three_q   <= 1'b0;
            drive_q   <= 1'b0;
            bit_q     <= 1'b0;
            i2c_off_q <= 1'b0;
            ovf_q     <= 1'b0;
            si_oe_q   <= 1'b0;
            so_oe_q   <= 1'b0;
        end
        else
        begin
            state_q   <= state_d;
            cnt_q     <= cnt_d;
            rx_q      <= rx_d;
            tx_q      <= tx_d;
            rd_byte_q <= rd_byte_d;
            addr_q    <= addr_d;
            rd_addr_q <= rd_addr_d;
            fetch_q   <= fetch_d;
            mode11_q  <= mode11_d;
            three_q   <= three_d;
            drive_q   <= drive_d;
            bit_q     <= bit_d;
            i2c_off_q <= i2c_off_d;
            ovf_q     <= ovf_d;
            si_oe_q   <= drive_d & three_d;
            so_oe_q   <= drive_d & ~three_d;
        end
    end

    // =========================================================================
    // Pin and status outputs, all from flops
    // =========================================================================
    assign serial_in_pin_o   = bit_q;
    assign serial_in_pin_oe  = si_oe_q;
    assign serial_out_pin_o  = bit_q;
    assign serial_out_pin_oe = so_oe_q;
    assign i2c_disable       = i2c_off_q;
    assign write_overflow    = ovf_q;
    assign reg_rd_addr       = rd_addr_q;

endmodule : spi_register_access_slave

// File: dv/spi_register_access_slave_props.sv
`timescale 1ns/1ps
// ==================================================
// Serial port checker
module spi_access_checker
    import spi_slave_pkg::*;
(
    // Clock and reset
    input wire logic              sys_clk,
    input wire logic              reset_n,
    // Serial pins
    input wire logic              chip_select_low,
    input wire logic              serial_clk,
    input wire logic              serial_in_pin_oe,
    input wire logic              serial_out_pin_o,
    input wire logic              serial_out_pin_oe,
    // Status and register side
    input wire logic              three_wire_enable,
    input wire logic              i2c_disable,
    input wire logic              reg_wr_valid,
    input wire logic              reg_wr_ready,
    input wire logic [ADDR_W-1:0] reg_rd_addr
);
    logic       sck_q;
    logic [3:0] fall_age_q;
    logic [3:0] fall_age_d;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // Cycles since the serial clock fell; saturates so a long idle never wraps
    always_comb
    begin
        fall_age_d = (sck_q && !serial_clk) ? 4'h0 : fall_age_q + {3'h0, fall_age_q != 4'hf};
    end

    // Registers only
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sck_q      <= 1'b0;
            fall_age_q <= 4'hf;
        end
        else
        begin
            sck_q      <= serial_clk;
            fall_age_q <= fall_age_d;
        end
    end

    // Frame edges as the pin shows them
    sequence sel_fall_s;
        $fell(chip_select_low);
    endsequence
    sequence sel_rise_s;
        $rose(chip_select_low);
    endsequence

    i2c_set_a: assert property (sel_fall_s |-> ##[1:6] i2c_disable)
        else $error("I2C port still enabled after select low");
    i2c_hold_a: assert property (i2c_disable |=> i2c_disable)
        else $error("I2C disable flag cleared without reset");
    out_pin_quiet_a: assert property (
        three_wire_enable && $past(three_wire_enable) |-> !serial_out_pin_oe)
        else $error("Data out pin driven in three-wire mode");
    in_pin_quiet_a: assert property (
        !three_wire_enable && !$past(three_wire_enable) |-> !serial_in_pin_oe)
        else $error("Data in pin driven in four-wire mode");
    out_on_fall_a: assert property (
        serial_out_pin_oe && $past(serial_out_pin_oe) && $changed(serial_out_pin_o)
        |-> fall_age_q inside {[1:5]})
        else $error("Output bit changed away from a clock fall");
    oe_release_a: assert property (
        sel_rise_s |-> ##[1:8] !(serial_out_pin_oe || serial_in_pin_oe))
        else $error("Data pin still driven after select high");
    oe_idle_a: assert property (chip_select_low [*8] |-> !serial_out_pin_oe && !serial_in_pin_oe)
        else $error("Data pin driven outside a frame");
    rd_step_a: assert property (
        !chip_select_low && (serial_out_pin_oe || serial_in_pin_oe) && $changed(reg_rd_addr)
        |-> reg_rd_addr == 7'($past(reg_rd_addr) + 7'h1))
        else $error("Read address moved by other than one");
    wr_hold_a: assert property (reg_wr_valid && !reg_wr_ready |=> reg_wr_valid)
        else $error("Write pair withdrawn before it was taken");
endmodule : spi_access_checker

bind spi_register_access_slave spi_access_checker spi_access_checker_inst (
    .sys_clk(sys_clk), .reset_n(reset_n), .chip_select_low(chip_select_low),
    .serial_clk(serial_clk), .serial_in_pin_oe(serial_in_pin_oe),
    .serial_out_pin_o(serial_out_pin_o), .serial_out_pin_oe(serial_out_pin_oe),
    .three_wire_enable(three_wire_enable), .i2c_disable(i2c_disable),
    .reg_wr_valid(reg_wr_valid), .reg_wr_ready(reg_wr_ready), .reg_rd_addr(reg_rd_addr));

// File: dv/spi_host_model.sv
`timescale 1ns/1ps
// ==================================================
// Serial host model
module spi_host_model (
    // Pacing clock
    input  wire logic sys_clk,
    // Serial pins
    input  wire logic miso,
    output logic      sel_low,
    output logic      sck,
    output logic      mosi,
    output logic      mosi_oe
);
    logic mode11_q = 1'b0;

    // Deselected, clock parked low, line driven
    initial
    begin
        sel_low = 1'b1;
        sck     = 1'b0;
        mosi    = 1'b0;
        mosi_oe = 1'b1;
    end

    // Half of a 160 ns serial period, moved on falling sys_clk edges
    task automatic half();
        repeat (4) @(negedge sys_clk);
    endtask : half

    // Clock settles at the mode's idle level before select moves
    task automatic open_frame(input logic mode11);
        mode11_q = mode11;
        sck      = mode11;
        mosi_oe  = 1'b1;
        half();
        sel_low = 1'b0;
        half();
    endtask : open_frame

    // MSB first; a released line toggles so stale data never reads back
    task automatic xfer(input logic [7:0] tx, input logic drive, input int n,
                        output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--)
        begin
            sck     = 1'b0;
            mosi_oe = drive;
            mosi    = drive ? tx[i] : ~mosi;
            half();
            sck   = 1'b1;
            rx[i] = miso;
            half();
        end
    endtask : xfer

    // Clock back to idle before select rises
    task automatic close_frame();
        sck = mode11_q;
        half();
        sel_low = 1'b1;
        half();
    endtask : close_frame
endmodule : spi_host_model

// File: dv/spi_register_access_slave_test.sv
`timescale 1ns/1ps
// ==================================================
// Serial port testbench
module spi_register_access_slave_test;
    import spi_slave_pkg::*;
    logic              sys_clk = 1'b0;
    logic              reset_n = 1'b0;
    logic              three_wire_enable = 1'b0;
    logic              reg_wr_ready = 1'b1;
    logic              sel_low, sck, host_mosi, host_oe, host_miso, sdi_wire;
    logic              sdi_o, sdi_oe, sdo_o, sdo_oe, i2c_disable, write_overflow, reg_wr_valid;
    logic [ADDR_W-1:0] reg_wr_addr, reg_rd_addr;
    logic [BYTE_W-1:0] reg_wr_data, reg_rd_data, rx;
    logic [BYTE_W-1:0] mem [128];
    logic [PAIR_W-1:0] wr_log [$];
    logic [4:0]        quiet_outs;
    int                failures = 0;
    int                total_checks = 0;

    // Device wins the shared line while enabled; an undriven out pin flips
    assign sdi_wire    = sdi_oe ? sdi_o : host_mosi;
    assign host_miso   = three_wire_enable ? sdi_wire : (sdo_oe ? sdo_o : ~sdo_o);
    assign reg_rd_data = mem[reg_rd_addr];
    assign quiet_outs  = {i2c_disable, write_overflow, reg_wr_valid, sdi_oe, sdo_oe};
    always #10 sys_clk = ~sys_clk;

    spi_register_access_slave spi_register_access_slave_inst (
        .sys_clk(sys_clk), .reset_n(reset_n), .chip_select_low(sel_low), .serial_clk(sck),
        .serial_in_pin_i(sdi_wire), .serial_in_pin_o(sdi_o), .serial_in_pin_oe(sdi_oe),
        .serial_out_pin_o(sdo_o), .serial_out_pin_oe(sdo_oe),
        .three_wire_enable(three_wire_enable), .i2c_disable(i2c_disable),
        .write_overflow(write_overflow), .reg_wr_valid(reg_wr_valid),
        .reg_wr_ready(reg_wr_ready), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data),
        .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data));
    spi_host_model spi_host_model_inst (.sys_clk(sys_clk), .miso(host_miso),
        .sel_low(sel_low), .sck(sck), .mosi(host_mosi), .mosi_oe(host_oe));

    // Register file model logs each taken pair; both parties driving is a fault
    always @(posedge sys_clk)
    begin
        if (reg_wr_valid === 1'b1 && reg_wr_ready === 1'b1)
        begin
            wr_log.push_back({reg_wr_addr, reg_wr_data});
            mem[reg_wr_addr] <= reg_wr_data;
        end
        if (sdi_oe === 1'b1 && host_oe === 1'b1)
            check("line clash", 16'h1, 16'h0);
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop

    // Bounded wait for the register side to take n pairs
    task automatic wait_log(input int n);
        for (int k = 0; wr_log.size() < n; k++)
        begin
            if (k == 2000)
            begin
                check("pairs taken", 16'(wr_log.size()), 16'(n));
                report_and_stop();
            end
            @(negedge sys_clk);
        end
    endtask : wait_log

    task automatic shift(input logic [7:0] tx, input logic drive, input int n);
        spi_host_model_inst.xfer(tx, drive, n, rx);
    endtask : shift

    task automatic t_reset();
        check("reset outputs", 16'(quiet_outs), 16'h0);
        $display("reset test done");
    endtask : t_reset

    // Two pairs in one frame, the first aimed at a high full address
    task automatic t_write(input logic mode11);
        logic [7:0] d;
        d = mode11 ? 8'h5a : 8'ha5;
        wr_log.delete();
        spi_host_model_inst.open_frame(mode11);
        shift(8'h77, 1'b1, 8);
        shift(d, 1'b1, 8);
        shift(8'h74, 1'b1, 8);
        shift(~d, 1'b1, 8);
        spi_host_model_inst.close_frame();
        wait_log(2);
        check("first pair", 16'(wr_log[0]), {1'b0, 7'h77, d});
        check("second pair", 16'(wr_log[1]), {1'b0, 7'h74, ~d});
        check("i2c off", 16'(i2c_disable), 16'h1);
        repeat (8) @(negedge sys_clk);
        $display("write test done, mode %0d", mode11);
    endtask : t_write

    // Burst read; each byte comes from the next register
    task automatic t_read(input logic mode11, input logic [6:0] a, input int n);
        spi_host_model_inst.open_frame(mode11);
        shift({1'b1, a}, 1'b1, 8);
        for (int k = 0; k < n; k++)
        begin
            shift(8'h00, !three_wire_enable, 8);
            check("read byte", 16'(rx), 16'(mem[7'(a + k)]));
            check("driven pin", 16'({sdi_oe, sdo_oe}), three_wire_enable ? 16'h2 : 16'h1);
        end
        spi_host_model_inst.close_frame();
        repeat (8) @(negedge sys_clk);
        check("pins released", 16'({sdi_oe, sdo_oe}), 16'h0);
        $display("read test done at %h", a);
    endtask : t_read

    // Select raised mid-byte during a read and during a write pair
    task automatic t_abort();
        spi_host_model_inst.open_frame(1'b0);
        shift(8'ha0, 1'b1, 8);
        shift(8'h00, 1'b1, 4);
        spi_host_model_inst.close_frame();
        repeat (8) @(negedge sys_clk);
        check("pins after abort", 16'({sdi_oe, sdo_oe}), 16'h0);
        wr_log.delete();
        spi_host_model_inst.open_frame(1'b1);
        shift(8'h21, 1'b1, 8);
        shift(8'hff, 1'b1, 5);
        spi_host_model_inst.close_frame();
        repeat (20) @(negedge sys_clk);
        check("partial pair", 16'(wr_log.size()), 16'h0);
        $display("abort test done");
    endtask : t_abort

    // Register side stalls while twelve pairs arrive, then drains
    task automatic t_overflow();
        reg_wr_ready = 1'b0;
        wr_log.delete();
        spi_host_model_inst.open_frame(1'b0);
        for (int i = 0; i < 12; i++)
        begin
            shift(8'h40 + 8'(i), 1'b1, 8);
            shift(8'(i), 1'b1, 8);
        end
        spi_host_model_inst.close_frame();
        check("overflow", 16'(write_overflow), 16'h1);
        reg_wr_ready = 1'b1;
        wait_log(FIFO_DEPTH);
        repeat (20) @(negedge sys_clk);
        check("pairs kept", 16'(wr_log.size() >= FIFO_DEPTH), 16'h1);
        check("eighth pair", 16'(wr_log[FIFO_DEPTH-1]), {1'b0, 7'h47, 8'h07});
        spi_host_model_inst.open_frame(1'b0);
        repeat (4) @(negedge sys_clk);
        check("overflow cleared", 16'(write_overflow), 16'h0);
        spi_host_model_inst.close_frame();
        $display("overflow test done");
    endtask : t_overflow

    // Reset in mid-run; only a reset may clear the sticky port flag
    task automatic t_reset_again();
        check("flag before reset", 16'(i2c_disable), 16'h1);
        reset_n = 1'b0;
        repeat (6) @(negedge sys_clk);
        reset_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        check("outputs after reset", 16'(quiet_outs), 16'h0);
        $display("second reset test done");
    endtask : t_reset_again

    // Main sequence
    initial
    begin
        for (int a = 0; a < 128; a++)
            mem[a] = 8'(a * 37 + 11);
        repeat (6) @(negedge sys_clk);
        reset_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        t_reset();
        t_write(1'b0);
        t_read(1'b0, 7'h76, 3);
        t_read(1'b1, 7'h7e, 3);
        three_wire_enable = 1'b1;
        t_write(1'b1);
        t_read(1'b0, 7'h10, 2);
        t_read(1'b1, 7'h77, 2);
        three_wire_enable = 1'b0;
        t_abort();
        t_overflow();
        t_reset_again();
        report_and_stop();
    end
endmodule : spi_register_access_slave_test
